// file: include/link_filter_consts.vh
// Constants for the radio link address filter
`ifndef LINK_FILTER_CONSTS_VH
`define LINK_FILTER_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_SYSTEM_KEY      8'h00
`define REG_CLUSTER         8'h04
`define REG_STATION         8'h08
`define REG_TARGET          8'h0C
`define REG_CHANNEL         8'h10
`define REG_STATUS          8'h14

// ----------------------------------------
// Reset values and special codes
// ----------------------------------------
`define RST_SYSTEM_KEY      16'h0000
`define RST_CLUSTER         8'h00
`define RST_STATION         8'h01
`define RST_TARGET          8'h01
`define RST_CHANNEL         5'h01
`define KEY_FORBIDDEN       16'hFFFF
`define STATION_FORBIDDEN   8'h00
`define TARGET_BROADCAST    8'h00
`define TARGET_NOBODY       8'hFF
`define CHANNEL_MIN         5'h01
`define CHANNEL_MAX         5'h14

// ----------------------------------------
// Frame header layout: byte index
// ----------------------------------------
`define HDR_KEY_HI          3'h0
`define HDR_KEY_LO          3'h1
`define HDR_CLUSTER         3'h2
`define HDR_TARGET          3'h3
`define HDR_SOURCE          3'h4

`endif

// file: verif/link_filter_asserts.sv
// Port checker for the radio link address filter
`timescale 1ns/1ps

module link_filter_asserts
#(
    parameter HDR_LEN = 5                  // Header bytes per frame
)
(
    // Clock and reset
    input wire        clk,
    input wire        reset,
    // Register port
    input wire        reg_rd,
    input wire [15:0] reg_rdata_ff,
    // Frame out to radio
    input wire        radio_tx_valid_ff,
    input wire [7:0]  radio_tx_data_ff,
    input wire        radio_tx_last_ff,
    input wire        radio_tx_ready,
    // Frame in from radio
    input wire        radio_rx_valid,
    input wire [7:0]  radio_rx_data,
    input wire        radio_rx_last,
    input wire        radio_rx_err,
    // Accepted payload to host
    input wire        host_rx_valid_ff,
    input wire [7:0]  host_rx_data_ff,
    input wire        host_rx_last_ff
);
    // ----------------------------------------
    // Frame tracking
    // ----------------------------------------
    reg        in_ff;                      // Inside a received frame
    reg        bad_ff;                     // Frame carried an error
    reg  [7:0] cnt_ff;                     // Bytes of frame seen so far
    reg  [7:0] tgt_ff;                     // Target byte of the frame
    wire       first   = radio_rx_valid && !in_ff;
    wire       bad_now = first ? radio_rx_err : bad_ff;
    wire [7:0] cnt_now = first ? 8'h00 : cnt_ff;

    // Error is only valid on the first byte, so latch it there
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            in_ff  <= 1'b0;
            bad_ff <= 1'b0;
            cnt_ff <= 8'h00;
            tgt_ff <= 8'h00;
        end
        else if (radio_rx_valid)
        begin
            in_ff  <= !radio_rx_last;
            bad_ff <= bad_now;
            cnt_ff <= cnt_now + 8'h01;
            if (cnt_now == 8'h03)
                tgt_ff <= radio_rx_data;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence tx_stall;
        radio_tx_valid_ff && !radio_tx_ready;
    endsequence

    sequence rx_in;
        radio_rx_valid ##1 host_rx_valid_ff;
    endsequence

    rdata_quiet_a: assert property (!$past(reg_rd)
        |-> reg_rdata_ff == 16'h0000)
        else $error("read data outside its slot");
    rx_follow_a: assert property (
        host_rx_valid_ff |-> $past(radio_rx_valid)
        && host_rx_data_ff == $past(radio_rx_data))
        else $error("payload byte not copied");
    rx_last_a: assert property (
        rx_in |-> host_rx_last_ff == $past(radio_rx_last))
        else $error("last flag wrong");
    err_drop_a: assert property (
        host_rx_valid_ff |-> !$past(bad_now))
        else $error("damaged frame delivered");
    hdr_hidden_a: assert property (
        host_rx_valid_ff |-> $past(cnt_now) >= HDR_LEN)
        else $error("header byte delivered");
    nobody_a: assert property (
        host_rx_valid_ff |-> $past(tgt_ff) != 8'hFF)
        else $error("frame for nobody delivered");
    tx_hold_a: assert property (
        tx_stall |=> radio_tx_valid_ff
        && $stable(radio_tx_data_ff) && $stable(radio_tx_last_ff))
        else $error("radio byte changed while stalled");
    tx_last_a: assert property (
        radio_tx_valid_ff && radio_tx_last_ff && radio_tx_ready
        |=> !(radio_tx_valid_ff && radio_tx_last_ff))
        else $error("last byte sent twice");

endmodule // link_filter_asserts

bind radio_link_address_filter link_filter_asserts #(.HDR_LEN(HDR_LEN)) chk (.*);

// file: verif/radio_peer_model.sv
// Peer radio model: stalling frame sink and frame source
`timescale 1ns/1ps

module radio_peer_model
(
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Frames from the filter
    input  wire        radio_tx_valid_ff,
    input  wire [7:0]  radio_tx_data_ff,
    output logic       radio_tx_ready,
    // Frames toward the filter
    output logic       radio_rx_valid,
    output logic [7:0] radio_rx_data,
    output logic       radio_rx_last,
    output logic       radio_rx_err,
    output logic [4:0] radio_rx_channel
);
    logic [7:0] txq[$];                    // Bytes taken from the filter

    initial
    begin
        radio_tx_ready   = 1'b0;
        radio_rx_valid   = 1'b0;
        radio_rx_data    = 8'h00;
        radio_rx_last    = 1'b0;
        radio_rx_err     = 1'b0;
        radio_rx_channel = 5'h01;
    end

    // Sink stalls one cycle in four to exercise the hold
    always @(posedge clk)
    begin
        if (radio_tx_valid_ff && radio_tx_ready)
            txq.push_back(radio_tx_data_ff);
        radio_tx_ready <= ($urandom_range(3) != 0);
    end

    // Error and channel count only on byte 0, so others are noise
    task automatic send(input logic [7:0] f[$], input logic e,
                        input logic [4:0] ch);
        int i;
        for (i = 0; i < f.size(); i++)
        begin
            @(posedge clk);
            radio_rx_valid   <= 1'b1;
            radio_rx_data    <= f[i];
            radio_rx_last    <= (i == f.size() - 1);
            radio_rx_err     <= (i == 0) ? e : 1'($urandom);
            radio_rx_channel <= (i == 0) ? ch : 5'($urandom);
            @(posedge clk);
            radio_rx_valid <= 1'b0;
            radio_rx_data  <= ~f[i];
            repeat ($urandom_range(1)) @(posedge clk);
        end
    endtask

endmodule // radio_peer_model

// file: verif/test_radio_link_address_filter.sv
// Self-checking bench for the radio link address filter
`timescale 1ns/1ps
`include "link_filter_consts.vh"

module test_radio_link_address_filter;
    // Driven inputs
    logic        clk, reset, reg_wr, reg_rd;
    logic        host_tx_valid, host_tx_last;
    logic [7:0]  reg_addr, host_tx_data;
    logic [15:0] reg_wdata;
    // Design and model outputs
    wire  [15:0] reg_rdata_ff;
    wire         host_tx_ready_ff, radio_tx_valid_ff, radio_tx_last_ff;
    wire         radio_tx_ready, radio_rx_valid, radio_rx_last;
    wire         radio_rx_err, host_rx_valid_ff, host_rx_last_ff;
    wire  [7:0]  radio_tx_data_ff, radio_rx_data, host_rx_data_ff;
    wire  [4:0]  radio_rx_channel;
    // Bench state
    int          n_fail, total_checks, cycles, acc, drop, r, i;
    logic [15:0] okey;                     // Own system key
    logic [7:0]  ocl, ost, otg;            // Own cluster, station, target
    logic [4:0]  och;                      // Own channel
    logic [7:0]  rxq[$];                   // Payload seen by host

    radio_link_address_filter #(.HDR_LEN(5)) dut (.*);
    radio_peer_model peer (.*);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, well above the thousand or so cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (host_rx_valid_ff === 1'b1)
            rxq.push_back(host_rx_data_ff);
        if (cycles == 30000)
        begin
            n_fail++;
            $display("wrong value at %0t: run hung", $time);
            complete_run;
        end
    end

    // ----------------------------------------
    // Checks, bus cycles, expectations
    // ----------------------------------------
    task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: reg %h not %h", $time, g, e);
        end
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: byte %h not %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk_reg(reg_rdata_ff, e);
    endtask

    function automatic logic acc_exp(logic [15:0] k, logic [7:0] c,
                                     logic [7:0] t, logic [4:0] ch, logic e);
        return !e && k == okey && c == ocl && ch == och && t != 8'hFF
               && (t == 8'h00 || t == ost);
    endfunction

    task automatic set_cfg;
        okey = 16'($urandom_range(16'hFFFE));
        ocl  = 8'($urandom);
        ost  = 8'(2 + $urandom_range(251));  // Keeps ost^1 clear of 00/FF
        otg  = 8'($urandom);
        och  = 5'(1 + $urandom_range(19));
        wr(`REG_SYSTEM_KEY, okey);
        wr(`REG_CLUSTER, {8'h00, ocl});
        wr(`REG_STATION, {8'h00, ost});
        wr(`REG_TARGET, {8'h00, otg});
        wr(`REG_CHANNEL, {11'h000, och});
    endtask

    // One frame with one field changed, or none, as chosen by kind
    task automatic rx_case(input int kind);
        logic [15:0] k;
        logic [7:0]  c, t;
        logic [4:0]  ch;
        logic        e;
        logic [7:0]  f[$], ex[$];
        k = okey; c = ocl; t = ost; ch = och; e = 1'b0;
        case (kind)
            1: t = 8'h00;                  // Broadcast
            2: t = 8'hFF;                  // Addressed to nobody
            3: t = ost ^ 8'h01;            // Another station
            4: e = 1'b1;                   // Damaged frame
            5: k = k ^ 16'h0100;           // Foreign system
            6: c = c ^ 8'h01;              // Foreign cluster
            7: ch = (och == 5'h14) ? 5'h01 : och + 5'h01;
            default: ;                     // Plain match
        endcase
        f = {k[15:8], k[7:0], c, t, 8'($urandom)};
        repeat (1 + $urandom_range(3)) f.push_back(8'($urandom));
        if (acc_exp(k, c, t, ch, e))
        begin
            ex = f[5:$];
            acc++;
        end
        else
            drop++;
        rxq = {};
        peer.send(f, e, ch);
        repeat (3) @(posedge clk);
        chk_byte(8'(rxq.size()), 8'(ex.size()));
        foreach (ex[j]) chk_byte(rxq[j], ex[j]);
    endtask

    // Header is snapshot of the settings when the send begins
    task automatic tx_case(input int n);
        logic [7:0] p[$], ex[$];
        int         j, w;
        repeat (n) p.push_back(8'($urandom));
        ex = {okey[15:8], okey[7:0], ocl, otg, ost};
        ex = {ex, p};
        peer.txq = {};
        @(posedge clk);
        for (j = 0; j < n; j++)
        begin
            host_tx_valid <= 1'b1;
            host_tx_data  <= p[j];
            host_tx_last  <= (j == n - 1);
            w = 0;
            do @(negedge clk); while (host_tx_ready_ff !== 1'b1 && ++w < 200);
            @(posedge clk);
        end
        host_tx_valid <= 1'b0;
        w = 0;
        while (peer.txq.size() < ex.size() && ++w < 200) @(posedge clk);
        chk_byte(8'(peer.txq.size()), 8'(ex.size()));
        foreach (ex[k]) chk_byte(peer.txq[k], ex[k]);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(38163));
        {reg_wr, reg_rd, host_tx_valid, host_tx_last} = 4'h0;
        {reg_addr, host_tx_data, reg_wdata} = 32'h0000_0000;
        reset = 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(`REG_SYSTEM_KEY, `RST_SYSTEM_KEY);
        rd(`REG_CLUSTER, 16'h0000);
        rd(`REG_STATION, 16'h0001);
        rd(`REG_TARGET, 16'h0001);
        rd(`REG_CHANNEL, 16'h0001);
        rd(`REG_STATUS, 16'h0000);
        rd(8'h18, 16'h0000);
        $display("test reset values done");
        wr(`REG_SYSTEM_KEY, 16'hFFFF);
        wr(`REG_STATION, 16'h0000);
        wr(`REG_CHANNEL, 16'h0000);
        wr(`REG_CHANNEL, 16'h0015);
        wr(8'h18, 16'h1234);
        rd(`REG_SYSTEM_KEY, 16'h0000);
        rd(`REG_STATION, 16'h0001);
        rd(`REG_CHANNEL, 16'h0001);
        wr(`REG_SYSTEM_KEY, 16'hFFFE);
        wr(`REG_STATION, 16'h00FF);
        wr(`REG_CLUSTER, 16'h00FF);
        wr(`REG_TARGET, 16'h0000);
        wr(`REG_CHANNEL, 16'h0014);
        rd(`REG_SYSTEM_KEY, 16'hFFFE);
        rd(`REG_STATION, 16'h00FF);
        rd(`REG_CLUSTER, 16'h00FF);
        rd(`REG_TARGET, 16'h0000);
        rd(`REG_CHANNEL, 16'h0014);
        $display("test register limits done");
        for (r = 0; r < 4; r++)
        begin
            set_cfg;
            for (i = 0; i < 8; i++)
                rx_case(r == 0 ? i : $urandom_range(7));
        end
        rd(`REG_STATUS, {8'(drop), 8'(acc)});
        $display("test receive filter done");
        for (r = 0; r < 4; r++)
        begin
            set_cfg;
            if (r == 1)
                otg = 8'hFF;
            wr(`REG_TARGET, {8'h00, otg});
            tx_case(r == 0 ? 1 : 1 + $urandom_range(5));
        end
        $display("test transmit header done");
        complete_run;
    end

endmodule // test_radio_link_address_filter

// file: verilog/link_accept_check.v
// Acceptance decision for one received frame header
`timescale 1ns/1ps
`include "link_filter_consts.vh"

module link_accept_check
(
    // Local identifiers
    input  wire [15:0] own_key,
    input  wire [7:0]  own_cluster,
    input  wire [7:0]  own_station,
    input  wire [4:0]  own_channel,
    // Fields seen in the frame
    input  wire [15:0] frm_key,
    input  wire [7:0]  frm_cluster,
    input  wire [7:0]  frm_target,
    input  wire [4:0]  frm_channel,
    input  wire        frm_err,
    // Verdict
    output wire        accept
);

    wire ids_ok;      // Key and cluster agree
    wire dest_ok;     // Addressed to us or to all
    wire chan_ok;     // Same carrier

    assign ids_ok  = (frm_key == own_key) &&
                     (frm_cluster == own_cluster);
    // Broadcast reaches every station; nobody-code reaches none
    assign dest_ok = (frm_target != `TARGET_NOBODY) &&
                     ((frm_target == `TARGET_BROADCAST) ||
                      (frm_target == own_station));
    assign chan_ok = (frm_channel == own_channel);
    assign accept  = !frm_err && ids_ok && dest_ok &&
                     chan_ok;

endmodule // link_accept_check

// file: verilog/radio_link_address_filter.v
// Link addressing: transmit header stamping and receive filtering
`timescale 1ns/1ps
`include "link_filter_consts.vh"

module radio_link_address_filter
#(
    parameter HDR_LEN = 5                  // Header bytes per frame
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata_ff,
    // Host payload to send
    input  wire        host_tx_valid,
    input  wire [7:0]  host_tx_data,
    input  wire        host_tx_last,
    output reg         host_tx_ready_ff,
    // Frame out to radio
    output reg         radio_tx_valid_ff,
    output reg  [7:0]  radio_tx_data_ff,
    output reg         radio_tx_last_ff,
    input  wire        radio_tx_ready,
    // Frame in from radio
    input  wire        radio_rx_valid,
    input  wire [7:0]  radio_rx_data,
    input  wire        radio_rx_last,
    input  wire        radio_rx_err,
    input  wire [4:0]  radio_rx_channel,
    // Accepted payload to host
    output reg         host_rx_valid_ff,
    output reg  [7:0]  host_rx_data_ff,
    output reg         host_rx_last_ff
);

    // ----------------------------------------
    // Local state
    // ----------------------------------------
    localparam TX_IDLE = 2'b00;           // Waiting for host data
    localparam TX_HDR  = 2'b01;           // Emitting header
    localparam TX_PAY  = 2'b10;           // Moving payload
    localparam RX_HDR  = 2'b00;           // Collecting header
    localparam RX_PAY  = 2'b01;           // Forwarding payload
    localparam RX_DROP = 2'b10;           // Swallowing rejected frame

    reg [15:0] key_ff;                    // System key
    reg [7:0]  cluster_ff;                // Cluster number
    reg [7:0]  station_ff;                // Local station number
    reg [7:0]  target_ff;                 // Target station number
    reg [4:0]  channel_ff;                // Carrier channel
    reg [7:0]  acc_cnt_ff;                // Frames accepted
    reg [7:0]  drop_cnt_ff;               // Frames discarded

    reg [1:0]  tx_st_ff;                  // Transmit state
    reg [2:0]  tx_idx_ff;                 // Header byte index
    reg [15:0] snap_key_ff;               // Identifiers frozen per send
    reg [7:0]  snap_cluster_ff;
    reg [7:0]  snap_target_ff;
    reg [7:0]  snap_station_ff;

    reg [1:0]  rx_st_ff;                  // Receive state
    reg [2:0]  rx_idx_ff;                 // Header byte index
    reg [15:0] frm_key_ff;                // Captured frame fields
    reg [7:0]  frm_cluster_ff;
    reg [7:0]  frm_target_ff;
    reg [4:0]  frm_channel_ff;
    reg        frm_err_ff;

    wire       accept;                    // Header verdict
    wire       slot_free;                 // Radio output slot empty or its byte taken this cycle
    reg  [7:0] hdr_byte;                  // Header byte to emit

    // ----------------------------------------
    // Acceptance check
    // ----------------------------------------
    link_accept_check u_check
    (
        .own_key     (key_ff),
        .own_cluster (cluster_ff),
        .own_station (station_ff),
        .own_channel (channel_ff),
        .frm_key     (frm_key_ff),
        .frm_cluster (frm_cluster_ff),
        .frm_target  (frm_target_ff),
        .frm_channel (frm_channel_ff),
        .frm_err     (frm_err_ff),
        .accept      (accept)
    );

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Illegal values are ignored so a bad write never breaks the link
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            key_ff     <= `RST_SYSTEM_KEY;
            cluster_ff <= `RST_CLUSTER;
            station_ff <= `RST_STATION;
            target_ff  <= `RST_TARGET;
            channel_ff <= `RST_CHANNEL;
        end
        else if (reg_wr)
        begin
            // Legal writes land at once; sends pick them up next frame
            case (reg_addr)
                `REG_SYSTEM_KEY:
                    if (reg_wdata != `KEY_FORBIDDEN)
                        key_ff <= reg_wdata;
                `REG_CLUSTER:
                    cluster_ff <= reg_wdata[7:0];
                `REG_STATION:
                    if (reg_wdata[7:0] != `STATION_FORBIDDEN)
                        station_ff <= reg_wdata[7:0];
                `REG_TARGET:
                    target_ff <= reg_wdata[7:0];
                `REG_CHANNEL:
                    if (reg_wdata[15:5] == 11'h000 &&
                        reg_wdata[4:0] >= `CHANNEL_MIN &&
                        reg_wdata[4:0] <= `CHANNEL_MAX)
                        channel_ff <= reg_wdata[4:0];
                default:
                    ;                                  // Unmapped: ignored
            endcase
        end
    end

    // ----------------------------------------
    // Register reads, data one cycle later
    // ----------------------------------------
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            reg_rdata_ff <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `REG_SYSTEM_KEY: reg_rdata_ff <= key_ff;
                `REG_CLUSTER:    reg_rdata_ff <= {8'h00, cluster_ff};
                `REG_STATION:    reg_rdata_ff <= {8'h00, station_ff};
                `REG_TARGET:     reg_rdata_ff <= {8'h00, target_ff};
                `REG_CHANNEL:    reg_rdata_ff <= {11'h000, channel_ff};
                `REG_STATUS:     reg_rdata_ff <= {drop_cnt_ff,
                                                  acc_cnt_ff};
                default:         reg_rdata_ff <= 16'h0000;
            endcase
        end
        else
            reg_rdata_ff <= 16'h0000;                  // Valid one cycle only
    end

    // ----------------------------------------
    // Transmit header byte select
    // ----------------------------------------
    always @*
    begin
        case (tx_idx_ff)
            `HDR_KEY_HI:  hdr_byte = snap_key_ff[15:8];
            `HDR_KEY_LO:  hdr_byte = snap_key_ff[7:0];
            `HDR_CLUSTER: hdr_byte = snap_cluster_ff;
            `HDR_TARGET:  hdr_byte = snap_target_ff;
            default:      hdr_byte = snap_station_ff;
        endcase
    end

    assign slot_free = !radio_tx_valid_ff || radio_tx_ready;

    // ----------------------------------------
    // Transmit sequencer
    // ----------------------------------------
    // One-byte output slot keeps outputs registered; costs throughput
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_st_ff          <= TX_IDLE;
            tx_idx_ff         <= 3'h0;
            snap_key_ff       <= `RST_SYSTEM_KEY;
            snap_cluster_ff   <= `RST_CLUSTER;
            snap_target_ff    <= `RST_TARGET;
            snap_station_ff   <= `RST_STATION;
            host_tx_ready_ff  <= 1'b0;
            radio_tx_valid_ff <= 1'b0;
            radio_tx_data_ff  <= 8'h00;
            radio_tx_last_ff  <= 1'b0;
        end
        else
        begin
            if (radio_tx_valid_ff && radio_tx_ready)
                radio_tx_valid_ff <= 1'b0;             // Byte taken
            case (tx_st_ff)
                TX_IDLE:
                    if (host_tx_valid)
                    begin
                        // Freeze identifiers for this whole frame
                        snap_key_ff     <= key_ff;
                        snap_cluster_ff <= cluster_ff;
                        snap_target_ff  <= target_ff;
                        snap_station_ff <= station_ff;
                        tx_idx_ff       <= 3'h0;
                        tx_st_ff        <= TX_HDR;
                    end
                TX_HDR:
                    if (slot_free)
                    begin
                        radio_tx_valid_ff <= 1'b1;
                        radio_tx_data_ff  <= hdr_byte;
                        radio_tx_last_ff  <= 1'b0;
                        if (tx_idx_ff == HDR_LEN - 1)
                            tx_st_ff <= TX_PAY;
                        else
                            tx_idx_ff <= tx_idx_ff + 3'h1;
                    end
                TX_PAY:
                    if (host_tx_ready_ff)
                    begin
                        if (host_tx_valid)
                        begin
                            // Payload byte moves into free slot
                            host_tx_ready_ff  <= 1'b0;
                            radio_tx_valid_ff <= 1'b1;
                            radio_tx_data_ff  <= host_tx_data;
                            radio_tx_last_ff  <= host_tx_last;
                            if (host_tx_last)
                                tx_st_ff <= TX_IDLE;
                        end
                    end
                    else if (slot_free)
                        host_tx_ready_ff <= 1'b1;
                default:
                    tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receive filter
    // ----------------------------------------
    // Radio cannot be stalled, so payload is passed straight through
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rx_st_ff         <= RX_HDR;
            rx_idx_ff        <= 3'h0;
            frm_key_ff       <= 16'h0000;
            frm_cluster_ff   <= 8'h00;
            frm_target_ff    <= 8'h00;
            frm_channel_ff   <= 5'h00;
            frm_err_ff       <= 1'b0;
            acc_cnt_ff       <= 8'h00;
            drop_cnt_ff      <= 8'h00;
            host_rx_valid_ff <= 1'b0;
            host_rx_data_ff  <= 8'h00;
            host_rx_last_ff  <= 1'b0;
        end
        else
        begin
            host_rx_valid_ff <= 1'b0;
            host_rx_last_ff  <= 1'b0;
            if (radio_rx_valid)
            begin
                case (rx_st_ff)
                    RX_HDR:
                    begin
                        // Every frame longer than the header is checked here
                        case (rx_idx_ff)
                            `HDR_KEY_HI:
                            begin
                                frm_key_ff[15:8] <= radio_rx_data;
                                frm_err_ff       <= radio_rx_err;
                                frm_channel_ff   <= radio_rx_channel;
                            end
                            `HDR_KEY_LO:
                                frm_key_ff[7:0] <= radio_rx_data;
                            `HDR_CLUSTER:
                                frm_cluster_ff <= radio_rx_data;
                            `HDR_TARGET:
                                frm_target_ff <= radio_rx_data;
                            default:
                                ;                      // Source not checked
                        endcase
                        if (radio_rx_last)
                        begin
                            // Runt frame: dropped and counted as discarded
                            rx_idx_ff   <= 3'h0;
                            drop_cnt_ff <= drop_cnt_ff + 8'h01;
                        end
                        else if (rx_idx_ff == HDR_LEN - 1)
                        begin
                            rx_idx_ff <= 3'h0;
                            if (accept)
                            begin
                                rx_st_ff   <= RX_PAY;
                                acc_cnt_ff <= acc_cnt_ff + 8'h01;
                            end
                            else
                            begin
                                rx_st_ff    <= RX_DROP;
                                drop_cnt_ff <= drop_cnt_ff + 8'h01;
                            end
                        end
                        else
                            rx_idx_ff <= rx_idx_ff + 3'h1;
                    end
                    RX_PAY:
                    begin
                        host_rx_valid_ff <= 1'b1;
                        host_rx_data_ff  <= radio_rx_data;
                        host_rx_last_ff  <= radio_rx_last;
                        if (radio_rx_last)
                            rx_st_ff <= RX_HDR;
                    end
                    RX_DROP:
                        if (radio_rx_last)
                            rx_st_ff <= RX_HDR;
                    default:
                        rx_st_ff <= RX_HDR;
                endcase
            end
        end
    end

endmodule // radio_link_address_filter
